// ### alc_cfg_top.sv
// limiter/clip/thermal configuration bank
// Contract
// - threshold code decodes 16 V to 2 V
// - threshold/slope register resets to 0x51
// - slope code sets reduction ratio 1:1..4:1
// - eight-bit battery knee, reset 0x22
// - left clip ceiling (n+1)/256, reset 0xFF
// - right clip ceiling same encoding, reset 0xFF
// - left heat-warning cut 0/1.5/3/5.625 dB
// - right heat-warning cut, reserved bits zero
// - tracking ramps threshold down below knee
// - link uses left limiter for both
// - heat warning readable as status bit
`timescale 1ns/1ns
module alc_cfg_top
  import alc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // control port register access
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // surrounding device state
  input wire logic [7:0] battery_level_in,
  input wire logic right_battery_track_en_in,
  input wire logic limiter_channel_link_in,
  input wire logic [6:0] left_limit_threshold_qv_in,
  input wire logic heat_warning_flag_in,
  // settings applied to the audio path
  output logic [6:0] right_limit_threshold_out,
  output logic right_limiter_own_out,
  output logic [8:0] left_clip_level_out,
  output logic [8:0] right_clip_level_out,
  output logic [5:0] left_heat_warn_cut_out,
  output logic [5:0] right_heat_warn_cut_out
);

  logic [7:0] right_limit_threshold_slope_q;
  logic [7:0] right_limit_threshold_slope_d;
  logic [7:0] right_battery_knee_level_q;
  logic [7:0] right_battery_knee_level_d;
  logic [7:0] left_clip_ceiling_q;
  logic [7:0] left_clip_ceiling_d;
  logic [7:0] right_clip_ceiling_q;
  logic [7:0] right_clip_ceiling_d;
  logic [7:0] heat_warning_gain_cut_q;
  logic [7:0] heat_warning_gain_cut_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic [6:0] thr_q;
  logic [6:0] thr_d;
  logic own_q;
  logic own_d;
  logic [8:0] clip_l_q;
  logic [8:0] clip_l_d;
  logic [8:0] clip_r_q;
  logic [8:0] clip_r_d;
  logic [5:0] cut_l_q;
  logic [5:0] cut_l_d;
  logic [5:0] cut_r_q;
  logic [5:0] cut_r_d;

  alc_thresh_if th ();

  assign th.thr_code = right_limit_threshold_slope_q[ALC_THR_MSB:ALC_THR_LSB];
  assign th.slope = right_limit_threshold_slope_q[ALC_SLOPE_MSB:ALC_SLOPE_LSB];
  assign th.knee = right_battery_knee_level_q;
  assign th.battery = battery_level_in;
  assign th.track_en = right_battery_track_en_in;

  alc_thresh_calc u_calc (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .th(th.calc)
  );

  // register writes
  always_comb
  begin
    right_limit_threshold_slope_d = right_limit_threshold_slope_q;
    right_battery_knee_level_d = right_battery_knee_level_q;
    left_clip_ceiling_d = left_clip_ceiling_q;
    right_clip_ceiling_d = right_clip_ceiling_q;
    heat_warning_gain_cut_d = heat_warning_gain_cut_q;
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        ALC_OFS_RIGHT_LIMIT_THRESHOLD_SLOPE:
          // reserved bit 2 dropped on write so it always reads zero
          right_limit_threshold_slope_d = reg_wdata_in & ALC_MASK_THRESHOLD_SLOPE;
        ALC_OFS_RIGHT_BATTERY_KNEE_LEVEL:
          right_battery_knee_level_d = reg_wdata_in;
        ALC_OFS_LEFT_CLIP_CEILING:
          left_clip_ceiling_d = reg_wdata_in;
        ALC_OFS_RIGHT_CLIP_CEILING:
          right_clip_ceiling_d = reg_wdata_in;
        ALC_OFS_HEAT_WARNING_GAIN_CUT:
          heat_warning_gain_cut_d = reg_wdata_in & ALC_MASK_GAIN_CUT;
        default:
          ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      right_limit_threshold_slope_q <= ALC_RST_RIGHT_LIMIT_THRESHOLD_SLOPE;
      right_battery_knee_level_q <= ALC_RST_RIGHT_BATTERY_KNEE_LEVEL;
      left_clip_ceiling_q <= ALC_RST_LEFT_CLIP_CEILING;
      right_clip_ceiling_q <= ALC_RST_RIGHT_CLIP_CEILING;
      heat_warning_gain_cut_q <= ALC_RST_HEAT_WARNING_GAIN_CUT;
    end
    else
    begin
      right_limit_threshold_slope_q <= right_limit_threshold_slope_d;
      right_battery_knee_level_q <= right_battery_knee_level_d;
      left_clip_ceiling_q <= left_clip_ceiling_d;
      right_clip_ceiling_q <= right_clip_ceiling_d;
      heat_warning_gain_cut_q <= heat_warning_gain_cut_d;
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        ALC_OFS_RIGHT_LIMIT_THRESHOLD_SLOPE:
          rdata_d = right_limit_threshold_slope_q;
        ALC_OFS_RIGHT_BATTERY_KNEE_LEVEL:
          rdata_d = right_battery_knee_level_q;
        ALC_OFS_LEFT_CLIP_CEILING:
          rdata_d = left_clip_ceiling_q;
        ALC_OFS_RIGHT_CLIP_CEILING:
          rdata_d = right_clip_ceiling_q;
        ALC_OFS_HEAT_WARNING_GAIN_CUT:
          rdata_d = heat_warning_gain_cut_q;
        ALC_OFS_HEAT_STATUS:
          rdata_d = {7'h00, heat_warning_flag_in};
        default:
          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata_out = rdata_q;

  // settings driven to the audio path
  always_comb
  begin
    // linked: right follows the left limiter, own settings ignored
    own_d = !limiter_channel_link_in;
    thr_d = limiter_channel_link_in ? left_limit_threshold_qv_in : th.thr_qv;
    clip_l_d = alc_clip_level(left_clip_ceiling_q);
    clip_r_d = alc_clip_level(right_clip_ceiling_q);
    cut_l_d = alc_gain_cut(heat_warning_gain_cut_q[ALC_CUT_L_MSB:ALC_CUT_L_LSB],
      heat_warning_flag_in);
    // code 2 shares the left table, 3 dB
    cut_r_d = alc_gain_cut(heat_warning_gain_cut_q[ALC_CUT_R_MSB:ALC_CUT_R_LSB],
      heat_warning_flag_in);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      thr_q <= 7'h00;
      own_q <= 1'b0;
      clip_l_q <= 9'h100;
      clip_r_q <= 9'h100;
      cut_l_q <= ALC_CUT_NONE;
      cut_r_q <= ALC_CUT_NONE;
    end
    else
    begin
      thr_q <= thr_d;
      own_q <= own_d;
      clip_l_q <= clip_l_d;
      clip_r_q <= clip_r_d;
      cut_l_q <= cut_l_d;
      cut_r_q <= cut_r_d;
    end
  end

  assign right_limit_threshold_out = thr_q;
  assign right_limiter_own_out = own_q;
  assign left_clip_level_out = clip_l_q;
  assign right_clip_level_out = clip_r_q;
  assign left_heat_warn_cut_out = cut_l_q;
  assign right_heat_warn_cut_out = cut_r_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_reset_values: assert property ($past(!rst_n_in) |->
    right_limit_threshold_slope_q == 8'h51 && right_battery_knee_level_q == 8'h22
    && left_clip_ceiling_q == 8'hFF && right_clip_ceiling_q == 8'hFF
    && heat_warning_gain_cut_q == 8'h00)
    else $error("register reset values wrong");
  chk_threshold_reserved: assert property (reg_rd_in
    && reg_addr_in == ALC_OFS_RIGHT_LIMIT_THRESHOLD_SLOPE |=> reg_rdata_out[2] == 1'b0)
    else $error("reserved threshold bit read nonzero");
  chk_knee_roundtrip: assert property (reg_wr_in
    && reg_addr_in == ALC_OFS_RIGHT_BATTERY_KNEE_LEVEL ##1 reg_rd_in && !reg_wr_in
    && reg_addr_in == ALC_OFS_RIGHT_BATTERY_KNEE_LEVEL |=>
    reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("knee write not read back");
  // output lags the register by one edge only
  chk_clip_left: assert property (1'b1 |=>
    left_clip_level_out == {1'b0, $past(left_clip_ceiling_q)} + 9'h001)
    else $error("left clip level wrong");
  chk_clip_right: assert property (right_clip_ceiling_q == 8'hFE |=>
    right_clip_level_out == 9'h0FF)
    else $error("right clip 0xFE must be 255/256");
  chk_left_cut: assert property (heat_warning_flag_in
    && heat_warning_gain_cut_q[1:0] == 2'h3 |=> left_heat_warn_cut_out == 6'h2D)
    else $error("left cut code 3 not 5.625 dB");
  chk_right_cut: assert property (heat_warning_flag_in
    && heat_warning_gain_cut_q[5:4] == 2'h2 |=> right_heat_warn_cut_out == 6'h18)
    else $error("right cut code 2 not 3 dB");
  chk_cut_gated: assert property (!heat_warning_flag_in |=>
    left_heat_warn_cut_out == 6'h00 && right_heat_warn_cut_out == 6'h00)
    else $error("cut applied without warning");
  chk_status_read: assert property (reg_rd_in && reg_addr_in == ALC_OFS_HEAT_STATUS |=>
    reg_rdata_out == {7'h00, $past(heat_warning_flag_in)})
    else $error("heat warning status wrong");
  chk_link_left: assert property (limiter_channel_link_in |=>
    !right_limiter_own_out && right_limit_threshold_out == $past(left_limit_threshold_qv_in))
    else $error("linked right not following left");

  cov_link: cover property (limiter_channel_link_in ##1 !limiter_channel_link_in);
  cov_heat_cut: cover property (heat_warning_flag_in && heat_warning_gain_cut_q != 8'h00);
  cov_status_read: cover property (reg_rd_in && reg_addr_in == ALC_OFS_HEAT_STATUS);
endmodule

// ### alc_pkg.sv
// constants, field layouts and decode helpers for the limiter/clip/thermal bank
package alc_pkg;

  // register offsets
  localparam logic [7:0] ALC_OFS_RIGHT_LIMIT_THRESHOLD_SLOPE = 8'h12;
  localparam logic [7:0] ALC_OFS_RIGHT_BATTERY_KNEE_LEVEL = 8'h13;
  localparam logic [7:0] ALC_OFS_LEFT_CLIP_CEILING = 8'h14;
  localparam logic [7:0] ALC_OFS_RIGHT_CLIP_CEILING = 8'h15;
  localparam logic [7:0] ALC_OFS_HEAT_WARNING_GAIN_CUT = 8'h16;
  localparam logic [7:0] ALC_OFS_HEAT_STATUS = 8'h18;

  // reset values
  localparam logic [7:0] ALC_RST_RIGHT_LIMIT_THRESHOLD_SLOPE = 8'h51;
  localparam logic [7:0] ALC_RST_RIGHT_BATTERY_KNEE_LEVEL = 8'h22;
  localparam logic [7:0] ALC_RST_LEFT_CLIP_CEILING = 8'hFF;
  localparam logic [7:0] ALC_RST_RIGHT_CLIP_CEILING = 8'hFF;
  localparam logic [7:0] ALC_RST_HEAT_WARNING_GAIN_CUT = 8'h00;

  // field positions
  localparam int ALC_THR_MSB = 7;
  localparam int ALC_THR_LSB = 3;
  localparam int ALC_SLOPE_MSB = 1;
  localparam int ALC_SLOPE_LSB = 0;
  localparam int ALC_CUT_R_MSB = 5;
  localparam int ALC_CUT_R_LSB = 4;
  localparam int ALC_CUT_L_MSB = 1;
  localparam int ALC_CUT_L_LSB = 0;
  localparam int ALC_STATUS_HEAT_BIT = 0;

  // writable bits per register
  localparam logic [7:0] ALC_MASK_THRESHOLD_SLOPE = 8'hFB;
  localparam logic [7:0] ALC_MASK_GAIN_CUT = 8'h33;

  // threshold decode, quarter volts: 16 V = 64, 9.5 V = 38, 8 V = 32
  localparam logic [6:0] ALC_QV_TOP = 7'h40;
  localparam logic [6:0] ALC_QV_FINE_TOP = 7'h26;
  localparam logic [6:0] ALC_QV_FINE_END = 7'h20;
  localparam logic [4:0] ALC_CODE_FINE_START = 5'h0D;
  localparam logic [4:0] ALC_CODE_FINE_END = 5'h13;

  // gain cut in eighths of a dB: 1.5, 3, 5.625 dB
  localparam logic [5:0] ALC_CUT_NONE = 6'h00;
  localparam logic [5:0] ALC_CUT_1P5 = 6'h0C;
  localparam logic [5:0] ALC_CUT_3P0 = 6'h18;
  localparam logic [5:0] ALC_CUT_5P625 = 6'h2D;

  // gain cut applied only while the warning is present
  function automatic logic [5:0] alc_gain_cut(input logic [1:0] code, input logic warn);
    logic [5:0] v;
    v = ALC_CUT_NONE;
    unique case (code)
      2'h0: v = ALC_CUT_NONE;
      2'h1: v = ALC_CUT_1P5;
      2'h2: v = ALC_CUT_3P0;
      2'h3: v = ALC_CUT_5P625;
    endcase
    return warn ? v : ALC_CUT_NONE;
  endfunction

  // clip ceiling in 1/256 of full scale: code n gives n+1
  function automatic logic [8:0] alc_clip_level(input logic [7:0] code);
    return {1'b0, code} + 9'h001;
  endfunction

  // threshold code to quarter volts
  function automatic logic [6:0] alc_thr_qv(input logic [4:0] code);
    logic [6:0] c;
    c = {2'h0, code};
    if (code <= ALC_CODE_FINE_START)
      return 7'(ALC_QV_TOP - (c << 1));
    else if (code <= ALC_CODE_FINE_END)
      return 7'(ALC_QV_FINE_TOP - (c - {2'h0, ALC_CODE_FINE_START}));
    else
      return 7'(ALC_QV_FINE_END - ((c - {2'h0, ALC_CODE_FINE_END}) << 1));
  endfunction

endpackage

// ### alc_thresh_if.sv
// carries threshold settings to the calculator and its result back
`timescale 1ns/1ns
interface alc_thresh_if;
  logic [4:0] thr_code;
  logic [1:0] slope;
  logic [7:0] knee;
  logic [7:0] battery;
  logic track_en;
  logic [6:0] thr_qv;

  modport cfg (output thr_code, output slope, output knee, output battery,
    output track_en, input thr_qv);
  modport calc (input thr_code, input slope, input knee, input battery,
    input track_en, output thr_qv);
endinterface

// ### alc_thresh_calc.sv
// right limiter threshold with battery tracking
`timescale 1ns/1ns
module alc_thresh_calc
  import alc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // settings and result
  alc_thresh_if.calc th
);

  logic [6:0] thr_q;
  logic [6:0] thr_d;
  logic [6:0] base;
  logic [7:0] drop;
  logic [9:0] cut;

  assign th.thr_qv = thr_q;

  always_comb
  begin
    base = alc_thr_qv(th.thr_code);
    drop = 8'h00;
    cut = 10'h000;
    thr_d = base;
    if (th.track_en && (th.battery < th.knee))
    begin
      drop = th.knee - th.battery;
      // ratio 1:1..4:1 is slope code plus one
      cut = 10'({2'h0, drop} * ({8'h00, th.slope} + 10'h001));
      // floor at zero; a deep sag must not wrap to a high threshold
      thr_d = ({3'h0, base} > cut) ? 7'({3'h0, base} - cut) : 7'h00;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      thr_q <= alc_thr_qv(ALC_RST_RIGHT_LIMIT_THRESHOLD_SLOPE[ALC_THR_MSB:ALC_THR_LSB]);
    else
      thr_q <= thr_d;
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_fixed_threshold: assert property (!th.track_en |=>
    thr_q == alc_thr_qv($past(th.thr_code)))
    else $error("fixed threshold not taken from code");
  chk_decode_points: assert property (th.thr_code == 5'h0E && !th.track_en |=>
    thr_q == 7'h25)
    else $error("code 14 must give 9.25 V");
  chk_slope_ratio: assert property (th.track_en && th.thr_code == 5'h00 && th.slope == 2'h3
    && th.knee == 8'h22 && th.battery == 8'h21 |=> thr_q == 7'h3C)
    else $error("4:1 slope misapplied");
  cov_tracking_cut: cover property (th.track_en && th.battery < th.knee);
endmodule

// ### test_amp_limiter_clip_thermal_cfg.sv
// self-checking bench for the limiter/clip/thermal configuration bank
`timescale 1ns/1ns
module test_amp_limiter_clip_thermal_cfg;
  import alc_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] battery_level_in = 8'h00;
  logic right_battery_track_en_in = 1'b0;
  logic limiter_channel_link_in = 1'b0;
  logic [6:0] left_limit_threshold_qv_in = 7'h00;
  logic heat_warning_flag_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [6:0] right_limit_threshold_out;
  logic right_limiter_own_out;
  logic [8:0] left_clip_level_out;
  logic [8:0] right_clip_level_out;
  logic [5:0] left_heat_warn_cut_out;
  logic [5:0] right_heat_warn_cut_out;
  int err_total = 0;
  int total_checks = 0;
  logic [7:0] rnd = 8'h56;
  logic [7:0] knee;
  logic [7:0] bat;
  logic [7:0] v;

  alc_cfg_top uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .battery_level_in(battery_level_in),
    .right_battery_track_en_in(right_battery_track_en_in),
    .limiter_channel_link_in(limiter_channel_link_in),
    .left_limit_threshold_qv_in(left_limit_threshold_qv_in),
    .heat_warning_flag_in(heat_warning_flag_in),
    .right_limit_threshold_out(right_limit_threshold_out),
    .right_limiter_own_out(right_limiter_own_out), .left_clip_level_out(left_clip_level_out),
    .right_clip_level_out(right_clip_level_out),
    .left_heat_warn_cut_out(left_heat_warn_cut_out),
    .right_heat_warn_cut_out(right_heat_warn_cut_out));

  always #4 sys_clk_in = ~sys_clk_in;

  // taps chosen for a maximal sequence, never locks at zero from a nonzero seed
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // threshold code to quarter volts, worked out independently
  function automatic logic [6:0] exp_thr(input int c);
    if (c <= 13)
      return 7'(64 - 2 * c);
    else if (c <= 19)
      return 7'(38 - (c - 13));
    return 7'(32 - 2 * (c - 19));
  endfunction

  function automatic logic [6:0] exp_track(input int c, input int s, input int k, input int b,
    input logic en);
    int t;
    t = int'(exp_thr(c));
    if (en && b < k)
      t = t - (k - b) * (s + 1);
    return (t < 0) ? 7'h00 : 7'(t);
  endfunction

  function automatic logic [5:0] exp_cut(input logic [1:0] c, input logic w);
    logic [5:0] r;
    r = (c == 2'h0) ? 6'd0 : (c == 2'h1) ? 6'd12 : (c == 2'h2) ? 6'd24 : 6'd45;
    return w ? r : 6'h00;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic roll();
    rnd = lfsr_next(rnd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // extra edge after the strobe so either answer timing is caught
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    check({8'h00, reg_rdata_out}, {8'h00, exp}, "read data");
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog so a stuck run still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(ALC_OFS_RIGHT_LIMIT_THRESHOLD_SLOPE, 8'h51);
    rd(ALC_OFS_RIGHT_BATTERY_KNEE_LEVEL, 8'h22);
    rd(ALC_OFS_LEFT_CLIP_CEILING, 8'hFF);
    rd(ALC_OFS_RIGHT_CLIP_CEILING, 8'hFF);
    rd(ALC_OFS_HEAT_WARNING_GAIN_CUT, 8'h00);
    check({7'h00, left_clip_level_out}, 16'h0100, "left clip at reset");
    check({10'h000, right_heat_warn_cut_out}, 16'h0000, "right cut at reset");
    $display("test reset_values done");
    // all threshold codes, reserved bit written high and dropped
    for (int c = 0; c < 32; c++)
    begin
      roll();
      wr(ALC_OFS_RIGHT_LIMIT_THRESHOLD_SLOPE, {5'(c), 1'b1, rnd[1:0]});
      settle();
      check({9'h000, right_limit_threshold_out}, {9'h000, exp_thr(c)}, "threshold");
      rd(ALC_OFS_RIGHT_LIMIT_THRESHOLD_SLOPE, {5'(c), 1'b0, rnd[1:0]});
    end
    $display("test threshold_codes done");
    // tracking against the knee, with battery often just below it
    for (int i = 0; i < 24; i++)
    begin
      roll();
      knee = rnd;
      roll();
      bat = rnd[7] ? rnd : knee - {4'h0, rnd[3:0]};
      roll();
      // corner: code 0, 4:1 slope, one step below the reset knee
      if (i == 0)
      begin
        knee = 8'h22;
        bat = 8'h21;
        rnd = 8'h03;
      end
      wr(ALC_OFS_RIGHT_BATTERY_KNEE_LEVEL, knee);
      wr(ALC_OFS_RIGHT_LIMIT_THRESHOLD_SLOPE, {rnd[7:3], 1'b0, rnd[1:0]});
      @(posedge sys_clk_in);
      battery_level_in <= bat;
      right_battery_track_en_in <= (i % 4 != 3);
      settle();
      check({9'h000, right_limit_threshold_out}, {9'h000, exp_track(int'(rnd[7:3]),
        int'(rnd[1:0]), int'(knee), int'(bat), (i % 4 != 3))}, "tracked threshold");
      rd(ALC_OFS_RIGHT_BATTERY_KNEE_LEVEL, knee);
    end
    $display("test battery_tracking done");
    check({15'h0000, right_limiter_own_out}, 16'h0001, "own while unlinked");
    @(posedge sys_clk_in);
    limiter_channel_link_in <= 1'b1;
    left_limit_threshold_qv_in <= 7'h2B;
    settle();
    check({9'h000, right_limit_threshold_out}, 16'h002B, "linked threshold");
    check({15'h0000, right_limiter_own_out}, 16'h0000, "own while linked");
    @(posedge sys_clk_in);
    limiter_channel_link_in <= 1'b0;
    $display("test limiter_link done");
    for (int i = 0; i < 12; i++)
    begin
      roll();
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFE : rnd;
      wr(ALC_OFS_LEFT_CLIP_CEILING, v);
      wr(ALC_OFS_RIGHT_CLIP_CEILING, ~v);
      settle();
      check({7'h00, left_clip_level_out}, 16'(v) + 16'h0001, "left clip");
      // invert at eight bits before widening
      check({7'h00, right_clip_level_out}, {8'h00, ~v} + 16'h0001, "right clip");
      rd(ALC_OFS_RIGHT_CLIP_CEILING, ~v);
    end
    $display("test clip_ceilings done");
    // every cut code on both channels, warning present and absent
    for (int i = 0; i < 32; i++)
    begin
      v = {2'b11, 2'(i >> 2), 2'b11, 2'(i)};
      wr(ALC_OFS_HEAT_WARNING_GAIN_CUT, v);
      @(posedge sys_clk_in);
      heat_warning_flag_in <= i[4];
      settle();
      check({10'h000, left_heat_warn_cut_out}, {10'h000, exp_cut(v[1:0], i[4])}, "left cut");
      check({10'h000, right_heat_warn_cut_out}, {10'h000, exp_cut(v[5:4], i[4])}, "right cut");
      rd(ALC_OFS_HEAT_WARNING_GAIN_CUT, v & 8'h33);
      rd(ALC_OFS_HEAT_STATUS, {7'h00, i[4]});
    end
    $display("test heat_warning_cut done");
    // status is read-only, unmapped places read zero
    wr(ALC_OFS_HEAT_STATUS, 8'hFF);
    rd(ALC_OFS_HEAT_STATUS, 8'h01);
    wr(8'h20, 8'hA5);
    rd(8'h20, 8'h00);
    rd(8'h17, 8'h00);
    $display("test unmapped_access done");
    report_and_stop();
  end
endmodule
